// *** shared/stack_frame_pkg.sv ***
// constants, frame codes and crc step shared by the command frame handler
package stack_frame_pkg;

  // ==========================================================================
  // frame initialization byte layout
  localparam int CMD_FLAG_BIT = 7;
  localparam int REQ_LSB = 4;
  localparam int REQ_W = 3;
  localparam int SIZE_LSB = 0;
  localparam int SIZE_W = 3;
  localparam int COUNT_W = 7;

  // ==========================================================================
  // request categories
  localparam logic [2:0] REQ_SINGLE_READ = 3'h0;
  localparam logic [2:0] REQ_SINGLE_WRITE = 3'h1;
  localparam logic [2:0] REQ_STACK_READ = 3'h2;
  localparam logic [2:0] REQ_STACK_WRITE = 3'h3;
  localparam logic [2:0] REQ_BCAST_READ = 3'h4;
  localparam logic [2:0] REQ_BCAST_WRITE = 3'h5;
  localparam logic [2:0] REQ_BCAST_REV_WRITE = 3'h6;

  // ==========================================================================
  // sizes and crc
  localparam int MAX_WRITE_BYTES = 8;
  localparam int PROTO_BYTES = 6;
  localparam int RESP_FIFO_DEPTH = 8;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY_REFL = 16'hA001;
  localparam logic [15:0] CRC_INVERT_MASK = 16'hFFFF;
  localparam logic [15:0] CRC_GOOD_RESIDUE = 16'h0000;

  // one byte of the serial crc, bit 0 first as on the wire
  function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc;
    for (int i = 0; i < 8; i++) begin
      if (c[0] ^ b[i]) begin
        c = (c >> 1) ^ CRC_POLY_REFL;
      end else begin
        c = c >> 1;
      end
    end
    return c;
  endfunction : crc_byte

endpackage : stack_frame_pkg

// *** logic/resp_fifo.sv ***
// response byte fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module resp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic [CW-1:0] count_q, count_d;
  logic doWr, doRd;

  // ==========================================================================
  // pointers and fill level
  always_comb begin
    inReady = (count_q != CNT_FULL);
    outValid = (count_q != '0);
    doWr = inValid && inReady;
    doRd = outValid && outReady;
    wrPtr_d = wrPtr_q;
    rdPtr_d = rdPtr_q;
    if (doWr) begin
      wrPtr_d = (wrPtr_q == PTR_LAST) ? '0 : wrPtr_q + PW'(1);
    end
    if (doRd) begin
      rdPtr_d = (rdPtr_q == PTR_LAST) ? '0 : rdPtr_q + PW'(1);
    end
    count_d = count_q + CW'(doWr) - CW'(doRd);
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      count_q <= count_d;
    end
  end

  // storage needs no reset; outValid masks stale words
  always_ff @(posedge mclk) begin
    if (doWr) begin
      mem[wrPtr_q] <= inData;
    end
  end

  assign outData = mem[rdPtr_q];
endmodule : resp_fifo
`default_nettype wire

// *** logic/stack_command_frame_handler.sv ***
// command and response frame handler of a stackable monitor device
//
// Functional notes
// - crc invert bit flips all response crc bits
// - command runs only with valid frame crc
// - writes give no response, reads do
// - request field selects write or read category
// - response carries init, address, register, data, crc
// - at most one response per command frame
// - single read init 0x80, size field zero
// - read count byte holds registers minus one
// - single write: address, register, one-eight bytes
// - unlock sequences arrive as one multi-byte write
// - stack read has no device address byte
// - stack read answered only by stack devices
// - device N waits for device N+1 response
// - bad upstream crc: withhold response, raise fault
// - response length is data plus six bytes
// - crc matches the documented read test vector
// - crc16 x16+x15+x2+1, start value all ones
// - crc runs in lsb-first serial order
// - crc mismatch discards frame, reports only crc
// - read count ignores its top bit
`timescale 1ns/1ps
`default_nettype none
module stack_command_frame_handler
  import stack_frame_pkg::*;
#(
  parameter int FIFO_DEPTH = RESP_FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [7:0] cmdByte,
  input wire logic cmdValid,
  output logic cmdReady,
  input wire logic [7:0] upByte,
  input wire logic upValid,
  output logic [7:0] respByte,
  output logic respValid,
  input wire logic respReady,
  output logic [15:0] regRdAddr,
  input wire logic [7:0] regRdData,
  output logic regWrEn,
  output logic [15:0] regWrAddr,
  output logic [7:0] regWrData,
  input wire logic [7:0] myAddress,
  input wire logic isStackDevice,
  input wire logic isTopOfStack,
  input wire logic responseCrcInvert,
  output logic crcErrorPulse,
  output logic upstreamCrcFault,
  output logic frameDone
);
  localparam logic [7:0] PROTO_LAST = 8'(PROTO_BYTES - 1);
  localparam logic [15:0] VEC_RESIDUE = crc_byte(crc_byte(crc_byte(crc_byte(crc_byte(
    crc_byte(crc_byte(CRC_INIT, 8'h80), 8'h00), 8'h02), 8'h15), 8'h0B), 8'hCB), 8'h49);
  typedef enum logic [3:0] {
    S_RECV = 4'b0001,
    S_WRITE = 4'b0010,
    S_WAIT = 4'b0100,
    S_RESP = 4'b1000
  } state_e;
  state_e state_q, state_d;
  logic [7:0] idx_q, idx_d, init_q, init_d, dev_q, dev_d;
  logic [15:0] reg_q, reg_d, crc_q, crc_d, rdAddr_q, rdAddr_d;
  logic [COUNT_W-1:0] cnt_q, cnt_d;
  logic [7:0] wbuf_q [MAX_WRITE_BYTES];
  logic [7:0] wbuf_d [MAX_WRITE_BYTES];
  logic wrEn_q, wrEn_d, crcErr_q, crcErr_d, fault_q, fault_d, done_q, done_d;
  logic [15:0] wrAddr_q, wrAddr_d;
  logic [7:0] wrData_q, wrData_d;
  logic [7:0] upIdx_q, upIdx_d, upLast_q, upLast_d, upDev_q, upDev_d;
  logic [15:0] upCrc_q, upCrc_d, upCrcNext;
  logic upEnd_q, upEnd_d, upGood_q, upGood_d, upNext_q, upNext_d;
  logic [2:0] req;
  logic isRead, isWrite, hasDev, addressed, waitNeeded;
  logic [3:0] dataN;
  logic [7:0] regHiPos, dataPos, crcPos, lastPos;
  logic [15:0] crcNext, txCrc;
  logic [7:0] respN, crcHiResp, respLastPos, pushByte;
  logic pushResp, fifoInReady, pushDone, respLast;
  // ==========================================================================
  // frame decode
  always_comb begin
    req = init_q[REQ_LSB +: REQ_W];
    isRead = init_q[CMD_FLAG_BIT] && (req == REQ_SINGLE_READ || req == REQ_STACK_READ
      || req == REQ_BCAST_READ);
    isWrite = init_q[CMD_FLAG_BIT] && (req == REQ_SINGLE_WRITE || req == REQ_STACK_WRITE
      || req == REQ_BCAST_WRITE || req == REQ_BCAST_REV_WRITE);
    hasDev = (req == REQ_SINGLE_READ || req == REQ_SINGLE_WRITE);
    // reads carry one count byte whatever the size field says
    dataN = isRead ? 4'h1 : {1'b0, init_q[SIZE_LSB +: SIZE_W]} + 4'h1;
    regHiPos = hasDev ? 8'h2 : 8'h1;
    dataPos = regHiPos + 8'h2;
    crcPos = dataPos + {4'h0, dataN};
    lastPos = crcPos + 8'h1;
    unique case (req)
      REQ_SINGLE_READ, REQ_SINGLE_WRITE: addressed = (dev_q == myAddress);
      REQ_STACK_READ, REQ_STACK_WRITE: addressed = isStackDevice;
      default: addressed = 1'b1;
    endcase
    waitNeeded = (req == REQ_STACK_READ || req == REQ_BCAST_READ) && !isTopOfStack;
    crcNext = crc_byte(crc_q, cmdByte);
    respN = {1'b0, cnt_q} + 8'h1;
    crcHiResp = respN + 8'h4;
    respLastPos = respN + PROTO_LAST;
    txCrc = {crc_q[7:0], crc_q[15:8]} ^ (responseCrcInvert ? CRC_INVERT_MASK : 16'h0000);
  end

  // ==========================================================================
  // command, write and response sequencing
  always_comb begin
    state_d = state_q;
    idx_d = idx_q;
    init_d = init_q;
    dev_d = dev_q;
    reg_d = reg_q;
    cnt_d = cnt_q;
    crc_d = crc_q;
    rdAddr_d = rdAddr_q;
    wbuf_d = wbuf_q;
    wrEn_d = 1'b0;
    wrAddr_d = wrAddr_q;
    wrData_d = wrData_q;
    crcErr_d = 1'b0;
    fault_d = 1'b0;
    done_d = 1'b0;
    cmdReady = 1'b0;
    pushResp = 1'b0;
    pushByte = 8'h00;
    unique case (state_q)
      S_RECV: begin
        cmdReady = 1'b1;
        if (cmdValid) begin
          crc_d = crcNext;
          idx_d = idx_q + 8'h1;
          if (idx_q == 8'h0) begin
            init_d = cmdByte;
          end else if (hasDev && idx_q == 8'h1) begin
            dev_d = cmdByte;
          end else if (idx_q == regHiPos) begin
            reg_d[15:8] = cmdByte;
          end else if (idx_q == regHiPos + 8'h1) begin
            reg_d[7:0] = cmdByte;
          end else if (idx_q < crcPos) begin
            cnt_d = cmdByte[COUNT_W-1:0];
            wbuf_d[3'(idx_q - dataPos)] = cmdByte;
          end
          if (idx_q != 8'h0 && idx_q == lastPos) begin
            idx_d = 8'h0;
            crc_d = CRC_INIT;
            if (crcNext != CRC_GOOD_RESIDUE) begin
              crcErr_d = 1'b1;
            end else begin
              done_d = 1'b1;
              rdAddr_d = reg_q;
              if (addressed && isRead) begin
                state_d = waitNeeded ? S_WAIT : S_RESP;
              end else if (addressed && isWrite) begin
                state_d = S_WRITE;
              end
            end
          end
        end
      end
      S_WRITE: begin
        // buffered bytes go out back to back so an unlock sequence stays whole
        wrEn_d = 1'b1;
        wrAddr_d = reg_q + {8'h00, idx_q};
        wrData_d = wbuf_q[idx_q[2:0]];
        idx_d = idx_q + 8'h1;
        if (idx_q == {4'h0, dataN} - 8'h1) begin
          idx_d = 8'h0;
          state_d = S_RECV;
        end
      end
      S_WAIT: begin
        // no timeout: a silent upper neighbour holds this device here
        if (upEnd_q) begin
          if (!upGood_q) begin
            fault_d = 1'b1;
            state_d = S_RECV;
          end else if (upNext_q) begin
            state_d = S_RESP;
          end
        end
      end
      S_RESP: begin
        pushResp = 1'b1;
        if (idx_q == 8'h0) begin
          pushByte = {1'b0, cnt_q};
        end else if (idx_q == 8'h1) begin
          pushByte = myAddress;
        end else if (idx_q == 8'h2) begin
          pushByte = reg_q[15:8];
        end else if (idx_q == 8'h3) begin
          pushByte = reg_q[7:0];
        end else if (idx_q < crcHiResp) begin
          pushByte = regRdData;
        end else if (idx_q == crcHiResp) begin
          pushByte = txCrc[15:8];
        end else begin
          pushByte = txCrc[7:0];
        end
        if (fifoInReady) begin
          idx_d = idx_q + 8'h1;
          if (idx_q < crcHiResp) begin
            crc_d = crc_byte(crc_q, pushByte);
          end
          if (idx_q > 8'h3 && idx_q < crcHiResp) begin
            rdAddr_d = rdAddr_q + 16'h0001;
          end
          if (idx_q == respLastPos) begin
            idx_d = 8'h0;
            crc_d = CRC_INIT;
            state_d = S_RECV;
          end
        end
      end
    endcase
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_q <= S_RECV;
      {idx_q, init_q, dev_q, reg_q, rdAddr_q, cnt_q} <= '0;
      crc_q <= CRC_INIT;
      wbuf_q <= '{default: 8'h00};
      {wrEn_q, wrAddr_q, wrData_q, crcErr_q, fault_q, done_q} <= '0;
    end else begin
      state_q <= state_d;
      {idx_q, init_q, dev_q, reg_q, rdAddr_q, cnt_q} <= {idx_d, init_d, dev_d, reg_d, rdAddr_d,
        cnt_d};
      crc_q <= crc_d;
      wbuf_q <= wbuf_d;
      {wrEn_q, wrAddr_q, wrData_q, crcErr_q, fault_q, done_q} <= {wrEn_d, wrAddr_d, wrData_d,
        crcErr_d, fault_d, done_d};
    end
  end
  // ==========================================================================
  // upstream response monitor
  always_comb begin
    upIdx_d = upIdx_q;
    upLast_d = upLast_q;
    upDev_d = upDev_q;
    upCrc_d = upCrc_q;
    upEnd_d = 1'b0;
    upGood_d = upGood_q;
    upNext_d = upNext_q;
    upCrcNext = crc_byte(upCrc_q, upByte);
    if (upValid) begin
      upCrc_d = upCrcNext;
      upIdx_d = upIdx_q + 8'h1;
      if (upIdx_q == 8'h0) begin
        upLast_d = {1'b0, upByte[COUNT_W-1:0]} + 8'(PROTO_BYTES);
      end else if (upIdx_q == 8'h1) begin
        upDev_d = upByte;
      end
      if (upIdx_q != 8'h0 && upIdx_q == upLast_q) begin
        upIdx_d = 8'h0;
        upCrc_d = CRC_INIT;
        upEnd_d = 1'b1;
        upGood_d = (upCrcNext == CRC_GOOD_RESIDUE);
        upNext_d = (upDev_q == myAddress + 8'h1);
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      {upIdx_q, upLast_q, upDev_q, upEnd_q, upGood_q, upNext_q} <= '0;
      upCrc_q <= CRC_INIT;
    end else begin
      {upIdx_q, upLast_q, upDev_q, upEnd_q, upGood_q, upNext_q} <= {upIdx_d, upLast_d, upDev_d,
        upEnd_d, upGood_d, upNext_d};
      upCrc_q <= upCrc_d;
    end
  end
  // ==========================================================================
  // response buffer and outputs
  resp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_resp_fifo (
    .mclk(mclk),
    .reset(reset),
    .inData(pushByte),
    .inValid(pushResp),
    .inReady(fifoInReady),
    .outData(respByte),
    .outValid(respValid),
    .outReady(respReady)
  );

  assign regRdAddr = rdAddr_q;
  assign regWrEn = wrEn_q;
  assign regWrAddr = wrAddr_q;
  assign regWrData = wrData_q;
  assign crcErrorPulse = crcErr_q;
  assign upstreamCrcFault = fault_q;
  assign frameDone = done_q;

  // ==========================================================================
  // checks
  assign pushDone = pushResp && fifoInReady;
  assign respLast = pushDone && (idx_q == respLastPos);

  sequence s_quiet4;
    (!pushResp && !wrEn_q)[*4];
  endsequence

  sequence s_write_end;
    cmdValid && cmdReady && idx_q != 8'h0 && idx_q == lastPos && isWrite
      && crcNext == CRC_GOOD_RESIDUE;
  endsequence

  a_crc_test_vector: assert property (@(posedge mclk) disable iff (reset)
    VEC_RESIDUE == CRC_GOOD_RESIDUE) else $error("crc test vector fails");
  a_bad_crc_drop: assert property (@(posedge mclk) disable iff (reset)
    (crcErr_q) |-> (state_q == S_RECV && !done_q) ##1 s_quiet4)
    else $error("frame with bad crc acted on");
  a_write_no_resp: assert property (@(posedge mclk) disable iff (reset)
    s_write_end |=> (!pushResp)[*8]) else $error("write frame produced a response");
  a_resp_length: assert property (@(posedge mclk) disable iff (reset)
    respLast |-> idx_q == {1'b0, cnt_q} + 8'h1 + 8'h5) else $error("response length wrong");
  a_crc_inverted: assert property (@(posedge mclk) disable iff (reset)
    pushResp && idx_q == crcHiResp |-> pushByte == (crc_q[7:0] ^ {8{responseCrcInvert}}))
    else $error("response crc high byte wrong");
  a_one_response: assert property (@(posedge mclk) disable iff (reset)
    respLast |=> state_q == S_RECV ##1 !pushResp) else $error("second response frame");
  a_wait_upper: assert property (@(posedge mclk) disable iff (reset)
    $past(state_q) == S_WAIT && state_q == S_RESP |-> $past(upEnd_q && upGood_q && upNext_q))
    else $error("responded before upper neighbour");
  a_up_fault: assert property (@(posedge mclk) disable iff (reset)
    state_q == S_WAIT && upEnd_q && !upGood_q |=> upstreamCrcFault && state_q == S_RECV
      ##1 !pushResp) else $error("bad upstream crc not handled");
  a_write_ascend: assert property (@(posedge mclk) disable iff (reset)
    regWrEn && $past(regWrEn) |-> regWrAddr == $past(regWrAddr) + 16'h0001)
    else $error("write addresses not consecutive");
endmodule : stack_command_frame_handler
`default_nettype wire

// *** tb/stack_frame_partner.sv ***
// far side model: register read port and the upper neighbour on the upstream lane
`timescale 1ns/1ps
`default_nettype none
module stack_frame_partner (
  input wire logic mclk,
  input wire logic [15:0] regRdAddr,
  output logic [7:0] regRdData,
  output logic [7:0] upByte,
  output logic upValid
);
  // ==========================================================================
  // register contents
  logic [7:0] upQ[$];
  logic [1:0] pace = 2'h0;
  // contents depend on the address only, so registers with the same high address byte can be told apart
  assign regRdData = regRdAddr[7:0] ^ regRdAddr[15:8] ^ 8'hA5;

  // ==========================================================================
  // upper neighbour
  initial begin
    upByte = 8'h00;
    upValid = 1'b0;
  end
  // pauses one cycle in four; an idle lane toggles so stale data never looks fresh
  always @(negedge mclk) begin
    pace <= pace + 2'h1;
    if (upQ.size() > 0 && pace != 2'h3) begin
      upByte <= upQ.pop_front();
      upValid <= 1'b1;
    end else begin
      upByte <= ~upByte;
      upValid <= 1'b0;
    end
  end
endmodule : stack_frame_partner
`default_nettype wire

// *** tb/test_stack_command_frame_handler.sv ***
// self-checking bench of the command frame handler
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module test_stack_command_frame_handler;
  import stack_frame_pkg::*;
  // ==========================================================================
  // signals
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] cmdByte = 8'h00;
  logic cmdValid = 1'b0;
  logic respReady = 1'b1;
  logic [7:0] myAddress = 8'h00;
  logic isStackDevice = 1'b0;
  logic isTopOfStack = 1'b1;
  logic responseCrcInvert = 1'b0;
  logic cmdReady, respValid, regWrEn, crcErrorPulse, upstreamCrcFault, frameDone, upValid;
  logic [7:0] upByte, respByte, regRdData, regWrData;
  logic [15:0] regRdAddr, regWrAddr;
  logic [31:0] seed = 32'h164E;
  logic stall = 1'b0;
  logic [2:0] cyc = 3'h0;
  logic [7:0] got[$];
  logic [7:0] exp[$];
  logic [7:0] fr[$];
  logic [23:0] wrs[$];
  logic [2:0] wtypes[4] = '{REQ_SINGLE_WRITE, REQ_STACK_WRITE, REQ_BCAST_WRITE,
                            REQ_BCAST_REV_WRITE};
  int errors = 0;
  int samples_checked = 0;
  int dones = 0;
  int crcErrs = 0;
  int faults = 0;
  int nGood = 0;
  int nBad = 0;

  stack_command_frame_handler u_dut (.mclk(mclk), .reset(reset), .cmdByte(cmdByte),
    .cmdValid(cmdValid), .cmdReady(cmdReady), .upByte(upByte), .upValid(upValid),
    .respByte(respByte), .respValid(respValid), .respReady(respReady),
    .regRdAddr(regRdAddr), .regRdData(regRdData), .regWrEn(regWrEn),
    .regWrAddr(regWrAddr), .regWrData(regWrData), .myAddress(myAddress),
    .isStackDevice(isStackDevice), .isTopOfStack(isTopOfStack),
    .responseCrcInvert(responseCrcInvert), .crcErrorPulse(crcErrorPulse),
    .upstreamCrcFault(upstreamCrcFault), .frameDone(frameDone));
  stack_frame_partner u_far (.mclk(mclk), .regRdAddr(regRdAddr), .regRdData(regRdData),
    .upByte(upByte), .upValid(upValid));

  // ==========================================================================
  // clock, drain side and monitors
  always #50 mclk = ~mclk;
  // drain stalls one cycle in eight, or for as long as a scenario holds it off
  always @(negedge mclk) begin
    cyc <= cyc + 3'h1;
    respReady <= !stall && cyc != 3'h6;
  end
  always @(posedge mclk) begin
    if (respValid === 1'b1 && respReady) got.push_back(respByte);
    if (regWrEn === 1'b1) wrs.push_back({regWrAddr, regWrData});
    if (frameDone === 1'b1) dones++;
    if (crcErrorPulse === 1'b1) crcErrs++;
    if (upstreamCrcFault === 1'b1) faults++;
  end

  // ==========================================================================
  // helpers
  function logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd
  function logic [15:0] crcStep(input logic [15:0] c, input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      c = (c[0] ^ b[i]) ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    return c;
  endfunction : crcStep
  function logic [7:0] regVal(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'hA5;
  endfunction : regVal

  task mkResp(input logic [7:0] dev, input logic [15:0] rg, input logic [7:0] cb,
              input logic [15:0] flip);
    logic [15:0] c;
    c = 16'hFFFF;
    exp.delete();
    exp.push_back(cb & 8'h7F);
    exp.push_back(dev);
    exp.push_back(rg[15:8]);
    exp.push_back(rg[7:0]);
    for (int k = 0; k <= cb[6:0]; k++) exp.push_back(regVal(rg + k[15:0]));
    foreach (exp[k]) c = crcStep(c, exp[k]);
    c = c ^ flip;
    // lsb-first crc: low register byte goes out first, so the frame value reads high first
    exp.push_back(c[7:0]);
    exp.push_back(c[15:8]);
  endtask : mkResp

  task sendFrame(input logic [7:0] init, input logic [7:0] dev, input logic [15:0] rg,
                 input int n, input logic [63:0] dat, input logic bad);
    logic [15:0] c;
    c = 16'hFFFF;
    fr.delete();
    fr.push_back(init);
    if (init[6:5] == 2'h0) fr.push_back(dev);
    fr.push_back(rg[15:8]);
    fr.push_back(rg[7:0]);
    for (int k = 0; k < n; k++) fr.push_back(dat[8*k +: 8]);
    foreach (fr[k]) c = crcStep(c, fr[k]);
    if (bad) c = ~c;
    fr.push_back(c[7:0]);
    fr.push_back(c[15:8]);
    nBad += bad;
    nGood += !bad;
    foreach (fr[k]) begin
      @(negedge mclk);
      cmdByte = fr[k];
      cmdValid = 1'b1;
      while (cmdReady !== 1'b1) @(negedge mclk);
    end
    @(negedge mclk);
    cmdValid = 1'b0;
  endtask : sendFrame

  task settle(input int len);
    for (int k = 0; k < 3000 && !(got.size() >= len && cmdReady === 1'b1
         && respValid !== 1'b1); k++) begin
      @(negedge mclk);
    end
    repeat (24) @(negedge mclk);
  endtask : settle

  task checkResp();
    `CHK(got.size(), exp.size())
    foreach (exp[k]) `CHK(got[k], exp[k])
    `CHK(wrs.size(), 0)
    got.delete();
  endtask : checkResp

  task checkWr(input logic [15:0] rg, input int n, input logic [63:0] dat);
    `CHK(wrs.size(), n)
    for (int k = 0; k < n; k++) `CHK(wrs[k], {rg + k[15:0], dat[8*k +: 8]})
    `CHK(got.size(), 0)
    wrs.delete();
  endtask : checkWr

  task results();
    if (errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results

  initial begin
    #(100 * 40000);
    errors++;
    results();
  end

  // ==========================================================================
  // scenarios
  initial begin
    logic [15:0] rg;
    logic [7:0] cb;
    logic [63:0] dat;
    repeat (12) @(negedge mclk);
    reset = 1'b0;
    // known vector with the drain held off so the fifo fills first
    stall = 1'b1;
    sendFrame(8'h80, 8'h00, 16'h0215, 1, 64'h0B, 1'b0);
    `CHK({fr[5], fr[6]}, 16'hCB49)
    repeat (40) @(negedge mclk);
    `CHK(respValid, 1'b1)
    stall = 1'b0;
    settle(18);
    mkResp(8'h00, 16'h0215, 8'h0B, 16'h0000);
    checkResp();
    // random reads; the last two are a bad crc and another device's address
    for (int i = 0; i < 8; i++) begin
      myAddress = 8'(rnd());
      rg = 16'(rnd());
      cb = 8'(rnd()) & 8'h8F;
      responseCrcInvert = 1'(rnd());
      sendFrame(8'h80, myAddress ^ {7'h00, i == 7}, rg, 1, {56'h0, cb}, i == 6);
      settle(i >= 6 ? 0 : cb[6:0] + 7);
      mkResp(myAddress, rg, cb, {16{responseCrcInvert}});
      if (i >= 6) exp.delete();
      checkResp();
    end
    // every write category, one to eight bytes, then a bad crc
    isStackDevice = 1'b1;
    for (int i = 0; i < 9; i++) begin
      rg = 16'(rnd());
      dat = {rnd(), rnd()};
      sendFrame({1'b1, wtypes[i % 4], 1'b0, 3'(i % 8)}, myAddress, rg, i % 8 + 1, dat,
                i == 8);
      settle(0);
      checkWr(rg, i == 8 ? 0 : i % 8 + 1, dat);
    end
    // top of stack: stack read as non-stack device, broadcast read, stack read
    responseCrcInvert = 1'b0;
    for (int i = 0; i < 3; i++) begin
      isStackDevice = i != 0;
      rg = 16'(rnd());
      cb = 8'(rnd()) & 8'h07;
      sendFrame(i == 1 ? 8'hC0 : 8'hA0, 8'h00, rg, 1, {56'h0, cb}, 1'b0);
      settle(i == 0 ? 0 : cb + 7);
      mkResp(myAddress, rg, cb, 16'h0000);
      if (i == 0) exp.delete();
      checkResp();
    end
    // lower device waits for its upper neighbour, whose second answer is corrupt
    isTopOfStack = 1'b0;
    myAddress = 8'h05;
    for (int i = 0; i < 2; i++) begin
      rg = 16'(rnd());
      cb = 8'(rnd()) & 8'h07;
      sendFrame(8'hA0, 8'h00, rg, 1, {56'h0, cb}, 1'b0);
      repeat (30) @(negedge mclk);
      `CHK(got.size(), 0)
      mkResp(8'h06, rg, cb, {15'h0, i == 1});
      foreach (exp[k]) u_far.upQ.push_back(exp[k]);
      settle(i == 1 ? 0 : cb + 7);
      mkResp(myAddress, rg, cb, 16'h0000);
      if (i == 1) exp.delete();
      checkResp();
    end
    `CHK(dones, nGood)
    `CHK(crcErrs, nBad)
    `CHK(faults, 1)
    results();
  end
endmodule : test_stack_command_frame_handler
`default_nettype wire
